// [step_dir_pkg.sv]
// Purpose: constants and types of the step/direction microstep sequencer
// Assumes: one system clock, synchronous active-high reset
// Notes: the sine table holds one quarter wave; the rest is derived by symmetry
//
// Summary of operation
// - only rising step edges and changes to coarser resolution move the sequencer; falling edges do nothing.
// - step and direction pass a two-flop synchroniser before any logic reads them.
// - position runs over a 1024-entry sine table, one electrical turn, four fullsteps.
// - each step edge adds width when direction low, subtracts it when high.
// - width is one entry at finest resolution, doubling per halving up to 256.
// - on change to coarser resolution, jump to the nearest valid position.
// - fullstep visits only 128, 384, 640 and 896, moving 256 per step.
// - half step starts at 64 by 128; quarter step starts at 32 by 64.
// - each step edge is interpolated into single-entry microsteps at 256x resolution.
// - last step interval is timed in clocks and split into equal microstep spacings.
// - step intervals beyond 2^20 clocks count as standstill.
// - standstill requests standby current reduction only when power-down select allows.
// - standstill flag sets on standstill and clears at the next step edge.
// - new rate adopted after one interval; pending microsteps abandoned at next edge.
// - index output is active where coil A sine crosses zero going positive.
// - position wraps from 1023 to 0 and back.
package step_dir_pkg;

    // ------------------------------------------------------------
    // position and resolution
    // ------------------------------------------------------------
    localparam int POS_W = 10;
    localparam logic [9:0] POS_RESET = 10'h000;
    localparam logic [9:0] QUARTER_TURN = 10'h100;
    localparam int RES_W = 4;
    localparam logic [3:0] RES_RESET = 4'h0;
    localparam logic [3:0] RES_FULLSTEP = 4'h8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int INTERVAL_W = 21;
    localparam int STANDSTILL_CLKS = 2 ** 20;

    // ------------------------------------------------------------
    // coil current
    // ------------------------------------------------------------
    localparam logic signed [8:0] AMP_MAX = 9'sh0ff;
    localparam logic signed [8:0] AMP_ZERO = 9'sh000;

    // quarter sine, 33 points at 8-entry spacing, full scale 255
    localparam logic [7:0] SINE_QUARTER [0:32] = '{
        8'h00, 8'h0d, 8'h19, 8'h25, 8'h32, 8'h3e, 8'h4a, 8'h56,
        8'h62, 8'h6d, 8'h78, 8'h83, 8'h8e, 8'h98, 8'ha2, 8'hab,
        8'hb4, 8'hbd, 8'hc5, 8'hcd, 8'hd4, 8'hdb, 8'he1, 8'he7,
        8'hec, 8'hf0, 8'hf4, 8'hf7, 8'hfa, 8'hfc, 8'hfe, 8'hff,
        8'hff};

    typedef struct packed {
        logic signed [8:0] coil_a;
        logic signed [8:0] coil_b;
    } coil_current_t;

endpackage : step_dir_pkg

// [step_dir_microstep_sequencer.sv]
// Purpose: step/direction front end with microstep table sequencer and interpolator
// Assumes: all pin inputs are asynchronous to clk_sys
// Notes: outputs are registered; coil values use linear interpolation of a quarter table
`timescale 1ns/1ns
module step_dir_microstep_sequencer #(
    parameter int STANDSTILL_LIMIT = step_dir_pkg::STANDSTILL_CLKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // step and direction pins
    input wire logic step_in,
    input wire logic dir_in,
    // configuration pins
    input wire logic [step_dir_pkg::RES_W-1:0] resolution,
    input wire logic interpolate_en,
    input wire logic power_down_select,
    // position and currents
    output logic [step_dir_pkg::POS_W-1:0] microstep_position,
    output step_dir_pkg::coil_current_t coil_current,
    // status
    output logic index_out,
    output logic standstill,
    output logic standby_request
);
    import step_dir_pkg::*;

    localparam int SYNC_W = RES_W + 4;
    localparam logic [INTERVAL_W-1:0] LIMIT = INTERVAL_W'(STANDSTILL_LIMIT);

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    logic step_s;
    logic dir_s;
    logic interp_s;
    logic pdn_s;
    logic [RES_W-1:0] res_s;
    logic [RES_W-1:0] res_clip;
    logic [RES_W-1:0] res_prev;
    logic [RES_W-1:0] res_step;
    logic step_prev;
    logic step_edge;
    logic coarser;
    logic [POS_W-1:0] width;
    logic [POS_W-1:0] target;
    logic [POS_W-1:0] base;
    logic [POS_W-1:0] next_target;
    logic [POS_W-1:0] next_pos;
    logic dir_latched;
    logic [INTERVAL_W-1:0] interval_cnt;
    logic [INTERVAL_W-1:0] last_interval;
    logic [INTERVAL_W-1:0] spacing;
    logic [INTERVAL_W-1:0] tick_cnt;
    logic tick;
    logic standstill_hit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // nearest grid point of a coarser width: the centre of the cell the position is in
    function automatic logic [POS_W-1:0] snap_to_grid(input logic [POS_W-1:0] pos,
                                                     input logic [POS_W-1:0] w);
        if (w == 10'h001) begin
            return pos;
        end
        return (pos & ~(w - 10'h001)) | (w >> 1);
    endfunction : snap_to_grid

    function automatic logic signed [8:0] sine_at(input logic [POS_W-1:0] pos);
        logic [8:0] ph;
        logic [5:0] k;
        logic [5:0] k1;
        logic [2:0] frac;
        logic [11:0] mix;
        logic signed [8:0] mag;
        ph = pos[8] ? (9'h100 - {1'b0, pos[7:0]}) : {1'b0, pos[7:0]};
        k = ph[8:3];
        frac = ph[2:0];
        k1 = (k == 6'h20) ? k : k + 6'h01;
        mix = {4'h0, SINE_QUARTER[k]} * (12'h008 - {9'h000, frac})
            + {4'h0, SINE_QUARTER[k1]} * {9'h000, frac};
        mag = {1'b0, mix[10:3]};
        return pos[9] ? -mag : mag;
    endfunction : sine_at

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_meta <= '0;
            sync_q <= '0;
        end else begin
            sync_meta <= {step_in, dir_in, interpolate_en, power_down_select, resolution};
            sync_q <= sync_meta;
        end
    end

    assign step_s = sync_q[SYNC_W-1];
    assign dir_s = sync_q[SYNC_W-2];
    assign interp_s = sync_q[SYNC_W-3];
    assign pdn_s = sync_q[SYNC_W-4];
    assign res_s = sync_q[RES_W-1:0];

    // ------------------------------------------------------------
    // edge and resolution tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            step_prev <= 1'b0;
            res_prev <= RES_RESET;
        end else begin
            step_prev <= step_s;
            res_prev <= res_clip;
        end
    end

    assign step_edge = step_s & ~step_prev;
    // codes above fullstep are treated as fullstep
    assign res_clip = (res_s > RES_FULLSTEP) ? RES_FULLSTEP : res_s;
    assign coarser = res_clip > res_prev;
    assign width = 10'h001 << res_clip;
    assign base = coarser ? snap_to_grid(target, width) : target;

    // ------------------------------------------------------------
    // step interval timing
    // ------------------------------------------------------------
    assign standstill_hit = (interval_cnt == LIMIT);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            interval_cnt <= LIMIT;
            last_interval <= LIMIT;
            res_step <= RES_RESET;
            dir_latched <= 1'b0;
        end else if (step_edge) begin
            interval_cnt <= '0;
            last_interval <= interval_cnt;
            res_step <= res_clip;
            dir_latched <= dir_s;
        end else if (!standstill_hit) begin
            interval_cnt <= interval_cnt + 21'h000001;
        end
    end

    // spacing is one share of the last interval per table entry of the step
    always_comb begin
        spacing = last_interval >> res_step;
        if (spacing == '0) begin
            spacing = 21'h000001;
        end
    end

    assign tick = (tick_cnt >= spacing - 21'h000001);

    always_ff @(posedge clk_sys) begin
        if (srst || step_edge || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 21'h000001;
        end
    end

    // ------------------------------------------------------------
    // sequencer and interpolator
    // ------------------------------------------------------------
    always_comb begin
        next_target = base;
        if (step_edge) begin
            next_target = dir_s ? base - width : base + width;
        end
    end

    always_comb begin
        next_pos = microstep_position;
        if (step_edge) begin
            // whatever is still pending is dropped here, a small jump
            next_pos = interp_s ? base : next_target;
        end else if (coarser || !interp_s || standstill_hit) begin
            next_pos = base;
        end else if (tick && microstep_position != target) begin
            // one table entry per tick, in the direction of the last edge
            next_pos = dir_latched ? microstep_position - 10'h001
                                   : microstep_position + 10'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            target <= POS_RESET;
            microstep_position <= POS_RESET;
        end else begin
            target <= next_target;
            microstep_position <= next_pos;
        end
    end

    // ------------------------------------------------------------
    // coil currents and index
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            coil_current.coil_a <= AMP_ZERO;
            coil_current.coil_b <= AMP_MAX;
            index_out <= 1'b1;
        end else begin
            coil_current.coil_a <= sine_at(next_pos);
            coil_current.coil_b <= sine_at(next_pos + QUARTER_TURN);
            index_out <= (next_pos == POS_RESET);
        end
    end

    // ------------------------------------------------------------
    // standstill and standby
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            standstill <= 1'b0;
        end else if (step_edge) begin
            standstill <= 1'b0;
        end else if (standstill_hit) begin
            standstill <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            standby_request <= 1'b0;
        end else begin
            standby_request <= standstill & pdn_s;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    property p_no_move_without_rise;
        !step_edge && !coarser |=> $stable(target);
    endproperty
    a_no_move_without_rise: assert property (p_no_move_without_rise)
        else $error("target moved without a rising step edge");

    property p_step_forward;
        step_edge && !dir_s && !coarser |=> target == 10'($past(target) + $past(width));
    endproperty
    a_step_forward: assert property (p_step_forward)
        else $error("forward step did not add the width");

    property p_step_reverse;
        step_edge && dir_s && !coarser |=> target == 10'($past(target) - $past(width));
    endproperty
    a_step_reverse: assert property (p_step_reverse)
        else $error("reverse step did not subtract the width");

    property p_fullstep_grid;
        res_clip == RES_FULLSTEP && res_prev == RES_FULLSTEP |-> target[7:0] == 8'h80;
    endproperty
    a_fullstep_grid: assert property (p_fullstep_grid)
        else $error("fullstep target off the 128 grid");

    property p_halfstep_grid;
        res_clip == 4'h7 && res_prev == 4'h7 ##1 res_prev == 4'h7 |-> target[6:0] == 7'h40;
    endproperty
    a_halfstep_grid: assert property (p_halfstep_grid)
        else $error("half step target off the 64 grid");

    property p_single_entry;
        !step_edge && !coarser && interp_s && !standstill_hit
            |=> 10'(microstep_position - $past(microstep_position))
                inside {10'h000, 10'h001, 10'h3ff};
    endproperty
    a_single_entry: assert property (p_single_entry)
        else $error("interpolated position moved by more than one entry");

    property p_standstill_set;
        // a step edge in the same cycle as the limit keeps the flag clear, so only the set without an edge is checked
        standstill_hit && !step_edge |=> standstill;
    endproperty
    a_standstill_set: assert property (p_standstill_set)
        else $error("standstill not flagged after the interval limit");

    property p_standstill_clear;
        step_edge |=> !standstill [*2];
    endproperty
    a_standstill_clear: assert property (p_standstill_clear)
        else $error("standstill not cleared by a step edge");

    property p_standby;
        standby_request |-> $past(standstill) && $past(pdn_s);
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby requested without standstill and power-down select");

    property p_index_zero;
        index_out |-> microstep_position == POS_RESET && coil_current.coil_b == AMP_MAX
            && coil_current.coil_a == AMP_ZERO;
    endproperty
    a_index_zero: assert property (p_index_zero)
        else $error("index active away from the positive zero crossing");

    property p_cosine;
        microstep_position == QUARTER_TURN |-> coil_current.coil_a == AMP_MAX
            && coil_current.coil_b == AMP_ZERO && !index_out;
    endproperty
    a_cosine: assert property (p_cosine)
        else $error("coil B not a quarter turn ahead of coil A");

endmodule : step_dir_microstep_sequencer

// [step_ctrl_model.sv]
// Purpose: motion controller model driving the step and direction pins
// Assumes: caller spaces pulses for the width in use
// Notes: pins are levels that the controller always drives, so nothing is released
`timescale 1ns/1ns
module step_ctrl_model (
    // clock
    input wire logic clk_sys,
    // step and direction pins
    output logic step_in,
    output logic dir_in
);
    initial begin
        step_in = 1'b0;
        dir_in = 1'b0;
    end

    // ------------------------------------------------------------
    // one step pulse
    // ------------------------------------------------------------
    // direction settles two clocks ahead so it crosses the synchroniser with the edge
    task automatic pulse(input logic d, input int hi, input int lo);
        @(posedge clk_sys);
        #1 dir_in = d;
        repeat (2) @(posedge clk_sys);
        #1 step_in = 1'b1;
        repeat (hi) @(posedge clk_sys);
        #1 step_in = 1'b0;
        repeat (lo) @(posedge clk_sys);
    endtask : pulse
endmodule : step_ctrl_model

// [tb_top.sv]
// Purpose: self-checking bench of the step/direction microstep sequencer
// Assumes: short standstill limit of 4096 clocks
// Notes: every position change outside the interpolated moves is matched against the oldest queued expectation
`timescale 1ns/1ns
module tb_top;
    import step_dir_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic step_in;
    logic dir_in;
    logic [RES_W-1:0] resolution = RES_RESET;
    logic interpolate_en = 1'b0;
    logic power_down_select = 1'b0;
    logic [POS_W-1:0] microstep_position;
    coil_current_t coil_current;
    logic index_out;
    logic standstill;
    logic standby_request;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 37315;
    int cycles = 0;
    int n;
    logic watch = 1'b0;
    logic [POS_W-1:0] exp_q [$];
    logic [POS_W-1:0] exp_pos = POS_RESET;
    logic [POS_W-1:0] last_pos;
    logic signed [8:0] ea;
    logic signed [8:0] eb;

    step_dir_microstep_sequencer #(.STANDSTILL_LIMIT(4096)) i_dut (
        .clk_sys(clk_sys), .srst(srst), .step_in(step_in), .dir_in(dir_in),
        .resolution(resolution), .interpolate_en(interpolate_en),
        .power_down_select(power_down_select), .microstep_position(microstep_position),
        .coil_current(coil_current), .index_out(index_out), .standstill(standstill),
        .standby_request(standby_request));
    step_ctrl_model i_ctrl (.clk_sys(clk_sys), .step_in(step_in), .dir_in(dir_in));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // width 2^code; a low time of 2*width+4 clocks keeps the fullstep rate legal
    task automatic step(input logic d, input int w);
        exp_pos = d ? exp_pos - w[POS_W-1:0] : exp_pos + w[POS_W-1:0];
        exp_q.push_back(exp_pos);
        i_ctrl.pulse(d, 2 + ($random(seed) & 7), 2 * w + 4);
    endtask : step

    task automatic set_res(input logic [RES_W-1:0] c);
        logic [POS_W-1:0] w;
        logic [POS_W-1:0] snap;
        w = 10'h001 << c;
        snap = (exp_pos & ~(w - 10'h001)) | (w >> 1);
        if (c > resolution && snap !== exp_pos) begin
            exp_pos = snap;
            exp_q.push_back(snap);
        end
        @(posedge clk_sys);
        #1 resolution = c;
        repeat (8) @(posedge clk_sys);
    endtask : set_res

    // ------------------------------------------------------------
    // output watcher and hang limit
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            results();
        end
        if (watch && microstep_position !== last_pos) begin
            if (exp_q.size() == 0) check("extra_move", microstep_position, last_pos);
            else check("microstep_position", microstep_position, exp_q.pop_front());
        end
        last_pos = microstep_position;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 srst = 1'b0;
        check("reset_pos", microstep_position, POS_RESET);
        check("reset_coil", coil_current, {AMP_ZERO, AMP_MAX});
        check("reset_index", index_out, 1'b1);
        check("reset_standby", standby_request, 1'b0);
        watch = 1'b1;
        n = 3 + ($random(seed) & 7);
        for (int i = 0; i < n; i++) step(1'b0, 1);
        for (int i = 0; i < n + 3; i++) step(1'b1, 1);
        for (int i = 0; i < 3; i++) step(1'b0, 1);
        check("index_at_zero", index_out, 1'b1);
        step(1'b0, 1);
        check("index_off_zero", index_out, 1'b0);
        for (int c = 1; c <= 8; c++) begin
            set_res(c[RES_W-1:0]);
            step($random(seed) & 1, 1 << c);
            step($random(seed) & 1, 1 << c);
        end
        for (int i = 0; i < 4; i++) begin
            step(1'b0, 256);
            ea = exp_pos[9] ? -9'sh0b4 : 9'sh0b4;
            eb = (exp_pos[9] ^ exp_pos[8]) ? -9'sh0b4 : 9'sh0b4;
            check("coil_fullstep", coil_current, {ea, eb});
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys);
            #1 power_down_select = p[0];
            repeat (4200) @(posedge clk_sys);
            #1 check("standstill_set", standstill, 1'b1);
            check("standby_set", standby_request, p[0]);
            step(1'b0, 256);
            check("standstill_clear", standstill, 1'b0);
            check("standby_clear", standby_request, 1'b0);
            repeat (2000) @(posedge clk_sys);
            #1 check("standstill_early", standstill, 1'b0);
        end
        // interpolated moves do not match one queue note per change, so the watcher rests
        watch = 1'b0;
        interpolate_en = 1'b1;
        for (int i = 0; i < 5; i++) begin
            exp_pos = exp_pos + QUARTER_TURN;
            i_ctrl.pulse(1'b0, 2, (i == 4) ? 4 : 590);
        end
        check("interp_midway", microstep_position == exp_pos, 1'b0);
        repeat (700) @(posedge clk_sys);
        #1 check("interp_target", microstep_position, exp_pos);
        results();
    end
endmodule : tb_top
